// >>> src/ialu_map.vh
// operation codes and flag positions of the integer datapath
`ifndef IALU_MAP_VH
`define IALU_MAP_VH
`define IALU_OP_ADD 5'h00
`define IALU_OP_ADC 5'h01
`define IALU_OP_INC 5'h02
`define IALU_OP_SUB 5'h03
`define IALU_OP_SBB 5'h04
`define IALU_OP_DEC 5'h05
`define IALU_OP_NEG 5'h06
`define IALU_OP_CMP 5'h07
`define IALU_OP_MUL 5'h08
`define IALU_OP_SMUL 5'h09
`define IALU_OP_DIV 5'h0a
`define IALU_OP_SDIV 5'h0b
`define IALU_OP_B2W 5'h0c
`define IALU_OP_W2D 5'h0d
`define IALU_OP_PADA 5'h0e
`define IALU_OP_PADS 5'h0f
`define IALU_OP_UADA 5'h10
`define IALU_OP_UADS 5'h11
`define IALU_OP_UADM 5'h12
`define IALU_OP_UADD 5'h13
`define IALU_OP_NOT 5'h14
`define IALU_OP_AND 5'h15
`define IALU_OP_OR 5'h16
`define IALU_OP_XOR 5'h17
`define IALU_OP_TEST 5'h18
`define IALU_OP_SHL 5'h19
`define IALU_OP_SHR 5'h1a
`define IALU_OP_SAR 5'h1b
`define IALU_OP_ROL 5'h1c
`define IALU_OP_ROR 5'h1d
`define IALU_OP_RCL 5'h1e
`define IALU_OP_RCR 5'h1f
`define IALU_F_CF 0
`define IALU_F_PF 1
`define IALU_F_AF 2
`define IALU_F_ZF 3
`define IALU_F_SF 4
`define IALU_F_OF 5
`define IALU_FLAGS_RST 6'h00
`define IALU_RES_RST 16'h0000
`endif

// >>> src/ialu_core.v
// integer alu with shifter, rotator, multiply, divide and decimal adjust
`timescale 1ns/1ns
`default_nettype none
`include "ialu_map.vh"
// Function
// RULE_01: operands are bytes or words, chosen by word_i per operation.
// RULE_02: decimal data is byte wide, packed two digits or unpacked one digit.
// RULE_03: each arithmetic operation updates six status flags from its result; inc and dec keep CF, multiply keeps AF, divide keeps CF, AF and OF.
// RULE_04: bytes read as unsigned, two's complement or nibble-per-digit decimal.
// RULE_05: add, add-carry, increment, subtract, subtract-borrow, decrement, negate, compare.
// RULE_06: unsigned and signed multiply and divide on bytes or words.
// RULE_07: sign extend byte to word and word to doubleword.
// RULE_08: packed decimal adjust after addition and after subtraction.
// RULE_09: unpacked adjust for add, subtract, multiply and before divide.
// RULE_10: logic, shifts and rotates work on bytes and words.
// RULE_11: complement, and, inclusive or, exclusive or.
// RULE_12: test computes and for flags only and writes no result.
// RULE_13: shift moves by count operand, counts up to 255.
// RULE_14: count is immediate or low byte of count register.
// RULE_15: left shift serves both forms; logical and arithmetic right shifts.
// RULE_16: rotates feed outgoing bits back in at the other end.
// RULE_17: rotate count comes from immediate or count register low byte.
// RULE_18: carry rotates treat carry flag as one extra operand bit.
// RULE_19: compare subtracts, updating flags only, no write back.
// RULE_20: left shift doubles per position; arithmetic right shift copies sign.
module ialu_core (
    input wire mclk_i,
    input wire resetn_i,
    input wire start_i,
    input wire [4:0] op_i,
    input wire word_i,
    input wire [15:0] a_i,
    input wire [15:0] b_i,
    input wire [15:0] ah_i,
    input wire [7:0] imm_count_i,
    input wire [7:0] count_register_low_byte_i,
    input wire count_sel_i,
    input wire [5:0] flags_i,
    output reg [15:0] result_o,
    output reg [15:0] result_hi_o,
    output reg [5:0] flags_o,
    output reg write_o,
    output reg write_hi_o,
    output reg div_err_o,
    output reg done_o
);
    reg [15:0] r;
    reg [15:0] rh;
    reg [5:0] f;
    reg wr;
    reg wrh;
    reg derr;
    reg [16:0] sum;
    reg [15:0] x;
    reg [15:0] y;
    reg cin;
    reg sub;
    reg arith;
    reg [31:0] prod;
    reg [31:0] dvd;
    reg [15:0] dvs;
    reg [31:0] q;
    reg [31:0] rm;
    reg [7:0] cnt;
    reg [16:0] rc;
    reg [7:0] al;
    reg [7:0] ahb;
    reg msb;
    reg cf;
    reg oldcf;
    reg neg_q;
    reg neg_r;
    reg [31:0] ua;
    reg [15:0] ub;
    integer i;
    // result sign bit for the selected width
    function top;
        input [15:0] v;
        input w;
        begin
            top = w ? v[15] : v[7];
        end
    endfunction
    always @* begin
        r = a_i;
        rh = 16'h0000;
        f = flags_i;
        wr = 1'b1; // see RULE_01
        wrh = 1'b0;
        derr = 1'b0;
        sum = 17'h0_0000;
        x = a_i;
        y = b_i;
        cin = 1'b0;
        sub = 1'b0;
        arith = 1'b0;
        prod = 32'h0000_0000;
        dvd = 32'h0000_0000;
        dvs = 16'h0001;
        q = 32'h0000_0000;
        rm = 32'h0000_0000;
        cnt = count_sel_i ? count_register_low_byte_i : imm_count_i; // see RULE_14 see RULE_17
        rc = 17'h0_0000;
        al = a_i[7:0];
        ahb = ah_i[7:0];
        msb = 1'b0;
        cf = flags_i[`IALU_F_CF];
        oldcf = flags_i[`IALU_F_CF];
        neg_q = 1'b0;
        neg_r = 1'b0;
        ua = 32'h0000_0000;
        ub = 16'h0000;
        if (!word_i) begin
            x = {8'h00, a_i[7:0]};
            y = {8'h00, b_i[7:0]};
        end
        case (op_i)
            `IALU_OP_ADD, `IALU_OP_ADC, `IALU_OP_INC, `IALU_OP_SUB, `IALU_OP_SBB,
            `IALU_OP_DEC, `IALU_OP_NEG, `IALU_OP_CMP: begin
                arith = 1'b1; // see RULE_05
                case (op_i)
                    `IALU_OP_ADC: cin = flags_i[`IALU_F_CF];
                    `IALU_OP_INC: y = 16'h0001;
                    `IALU_OP_SUB, `IALU_OP_CMP: sub = 1'b1;
                    `IALU_OP_SBB: begin
                        sub = 1'b1;
                        cin = flags_i[`IALU_F_CF];
                    end
                    `IALU_OP_DEC: begin
                        sub = 1'b1;
                        y = 16'h0001;
                    end
                    `IALU_OP_NEG: begin
                        sub = 1'b1;
                        y = x;
                        x = 16'h0000;
                    end
                    default: cin = 1'b0;
                endcase
                if (sub) begin
                    sum = {1'b0, x} - {1'b0, y} - {16'h0000, cin};
                end else begin
                    sum = {1'b0, x} + {1'b0, y} + {16'h0000, cin};
                end
                r = sum[15:0];
                if (word_i) begin
                    cf = sum[16];
                end else begin
                    cf = sum[8];
                end
                f[`IALU_F_OF] = (top(x, word_i) ^ top(r, word_i)) &
                    (sub ? (top(x, word_i) ^ top(y, word_i)) : ~(top(x, word_i) ^ top(y, word_i)));
                f[`IALU_F_AF] = x[4] ^ y[4] ^ r[4];
                if (op_i == `IALU_OP_INC || op_i == `IALU_OP_DEC) begin
                    cf = flags_i[`IALU_F_CF];
                end
                if (op_i == `IALU_OP_NEG) begin
                    cf = (word_i ? a_i : {8'h00, a_i[7:0]}) != 16'h0000;
                end
                if (op_i == `IALU_OP_CMP) begin
                    wr = 1'b0; // see RULE_19
                end
            end
            `IALU_OP_MUL, `IALU_OP_SMUL: begin
                if (op_i == `IALU_OP_SMUL) begin
                    if (word_i) begin
                        prod = $signed(a_i) * $signed(b_i); // see RULE_06
                    end else begin
                        prod = {{16{a_i[7]}}, {{8{a_i[7]}}, a_i[7:0]}} * {{16{b_i[7]}}, {{8{b_i[7]}}, b_i[7:0]}};
                    end
                end else begin
                    prod = {16'h0000, x} * {16'h0000, y};
                end
                if (word_i) begin
                    r = prod[15:0];
                    rh = prod[31:16];
                    wrh = 1'b1;
                    cf = (op_i == `IALU_OP_SMUL) ? (prod[31:16] != {16{prod[15]}}) : (prod[31:16] != 16'h0000);
                end else begin
                    r = prod[15:0];
                    cf = (op_i == `IALU_OP_SMUL) ? (prod[15:8] != {8{prod[7]}}) : (prod[15:8] != 8'h00);
                end
                f[`IALU_F_OF] = cf;
            end
            `IALU_OP_DIV, `IALU_OP_SDIV: begin
                // dividend is ah_i:a_i for words, a_i word for bytes
                dvd = word_i ? {ah_i, a_i} : {16'h0000, a_i};
                dvs = word_i ? b_i : {8'h00, b_i[7:0]};
                if (op_i == `IALU_OP_SDIV) begin
                    neg_q = (word_i ? dvd[31] : dvd[15]) ^ (word_i ? dvs[15] : dvs[7]);
                    neg_r = word_i ? dvd[31] : dvd[15];
                    ua = word_i ? (dvd[31] ? (32'h0000_0000 - dvd) : dvd) :
                        {16'h0000, (dvd[15] ? (16'h0000 - dvd[15:0]) : dvd[15:0])};
                    ub = word_i ? (dvs[15] ? (16'h0000 - dvs) : dvs) :
                        {8'h00, (dvs[7] ? (8'h00 - dvs[7:0]) : dvs[7:0])};
                end else begin
                    ua = dvd;
                    ub = dvs;
                end
                if (ub == 16'h0000) begin
                    derr = 1'b1; // see RULE_06
                    wr = 1'b0;
                end else begin
                    q = ua / {16'h0000, ub};
                    rm = ua % {16'h0000, ub};
                    if (neg_q) q = 32'h0000_0000 - q;
                    if (neg_r) rm = 32'h0000_0000 - rm;
                    if (word_i) begin
                        derr = (op_i == `IALU_OP_SDIV) ? (q[31:15] != {17{q[15]}}) : (q[31:16] != 16'h0000);
                        r = q[15:0];
                        rh = rm[15:0];
                        wrh = ~derr;
                    end else begin
                        derr = (op_i == `IALU_OP_SDIV) ? (q[31:7] != {25{q[7]}}) : (q[31:8] != 24'h00_0000);
                        r = {rm[7:0], q[7:0]};
                    end
                    wr = ~derr;
                end
            end
            `IALU_OP_B2W: r = {{8{a_i[7]}}, a_i[7:0]}; // see RULE_07
            `IALU_OP_W2D: begin
                r = a_i;
                rh = {16{a_i[15]}}; // see RULE_07
                wrh = 1'b1;
            end
            `IALU_OP_PADA, `IALU_OP_PADS: begin
                // packed digits, one per nibble of al
                cf = 1'b0; // see RULE_02 see RULE_08
                f[`IALU_F_AF] = 1'b0;
                r = {8'h00, al};
                if (al[3:0] > 4'h9 || flags_i[`IALU_F_AF]) begin
                    r[7:0] = (op_i == `IALU_OP_PADA) ? (al + 8'h06) : (al - 8'h06);
                    f[`IALU_F_AF] = 1'b1;
                end
                if (al > 8'h99 || oldcf) begin
                    r[7:0] = (op_i == `IALU_OP_PADA) ? (r[7:0] + 8'h60) : (r[7:0] - 8'h60);
                    cf = 1'b1;
                end
                r[15:8] = a_i[15:8];
            end
            `IALU_OP_UADA, `IALU_OP_UADS: begin
                // unpacked digit in al, carry into ah
                if (al[3:0] > 4'h9 || flags_i[`IALU_F_AF]) begin // see RULE_09
                    if (op_i == `IALU_OP_UADA) begin
                        al = al + 8'h06;
                        ahb = ahb + 8'h01;
                    end else begin
                        al = al - 8'h06;
                        ahb = ahb - 8'h01;
                    end
                    cf = 1'b1;
                end else begin
                    cf = 1'b0;
                end
                f[`IALU_F_AF] = cf;
                r = {ahb, 4'h0, al[3:0]};
            end
            `IALU_OP_UADM: r = {(al / 8'h0a), (al % 8'h0a)}; // see RULE_09
            `IALU_OP_UADD: r = {8'h00, (ahb * 8'h0a) + al}; // see RULE_09
            `IALU_OP_NOT: r = ~a_i; // see RULE_11
            `IALU_OP_AND, `IALU_OP_TEST: begin
                r = a_i & b_i; // see RULE_11
                cf = 1'b0;
                f[`IALU_F_OF] = 1'b0;
                if (op_i == `IALU_OP_TEST) wr = 1'b0; // see RULE_12
            end
            `IALU_OP_OR, `IALU_OP_XOR: begin
                r = (op_i == `IALU_OP_OR) ? (a_i | b_i) : (a_i ^ b_i); // see RULE_11
                cf = 1'b0;
                f[`IALU_F_OF] = 1'b0;
            end
            default: begin
                // shifts and rotates, one position per loop pass up to the count
                r = x; // see RULE_10
                for (i = 0; i < 256; i = i + 1) begin
                    if (i < cnt) begin // see RULE_13
                        msb = top(r, word_i);
                        case (op_i)
                            `IALU_OP_SHL: begin
                                cf = msb;
                                r = {r[14:0], 1'b0}; // see RULE_15 see RULE_20
                            end
                            `IALU_OP_SHR: begin
                                cf = r[0];
                                r = {1'b0, r[15:1]}; // see RULE_15
                            end
                            `IALU_OP_SAR: begin
                                cf = r[0];
                                r = {1'b0, r[15:1]};
                                if (word_i) r[15] = msb; else r[7] = msb; // see RULE_20
                            end
                            `IALU_OP_ROL: begin
                                cf = msb;
                                r = {r[14:0], msb}; // see RULE_16
                            end
                            `IALU_OP_ROR: begin
                                cf = r[0];
                                r = {r[0], r[15:1]}; // see RULE_16
                                if (!word_i) r[7] = cf;
                            end
                            `IALU_OP_RCL: begin
                                r = {r[14:0], cf}; // see RULE_18
                                cf = msb;
                            end
                            default: begin
                                rc = {cf, r};
                                cf = r[0]; // see RULE_18
                                r = rc[16:1];
                                if (!word_i) r[7] = rc[16];
                            end
                        endcase
                        if (!word_i) r[15:8] = 8'h00;
                    end
                end
                if (cnt == 8'h00) cf = oldcf;
                if (cnt == 8'h01) begin
                    f[`IALU_F_OF] = (op_i == `IALU_OP_SHR) ? top(x, word_i) :
                        (op_i == `IALU_OP_SAR) ? 1'b0 : (top(r, word_i) ^ cf);
                end
            end
        endcase
        if (!word_i && op_i != `IALU_OP_B2W && op_i != `IALU_OP_UADM && op_i != `IALU_OP_UADD &&
            op_i != `IALU_OP_UADA && op_i != `IALU_OP_UADS && op_i != `IALU_OP_PADA &&
            op_i != `IALU_OP_PADS && op_i != `IALU_OP_DIV && op_i != `IALU_OP_SDIV &&
            op_i != `IALU_OP_MUL && op_i != `IALU_OP_SMUL) begin
            r[15:8] = a_i[15:8];
            if (op_i >= `IALU_OP_ADD && op_i <= `IALU_OP_CMP || op_i >= `IALU_OP_NOT) begin
                r[15:8] = 8'h00;
            end
        end
        f[`IALU_F_CF] = cf;
        // zero, sign and parity from the low result, see RULE_03 see RULE_04
        f[`IALU_F_ZF] = word_i ? (r == 16'h0000) : (r[7:0] == 8'h00);
        f[`IALU_F_SF] = top(r, word_i);
        f[`IALU_F_PF] = ~^r[7:0];
    end
    always @(posedge mclk_i) begin
        if (!resetn_i) begin
            result_o <= `IALU_RES_RST;
            result_hi_o <= `IALU_RES_RST;
            flags_o <= `IALU_FLAGS_RST;
            write_o <= 1'b0;
            write_hi_o <= 1'b0;
            div_err_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= start_i;
            write_o <= start_i & wr;
            write_hi_o <= start_i & wrh;
            div_err_o <= start_i & derr;
            if (start_i) begin
                result_o <= r;
                result_hi_o <= rh;
                flags_o <= f; // see RULE_03
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/ialu_chk_assertions.sv
// concurrent checks on the integer datapath ports
`timescale 1ns/1ns
`default_nettype none
`include "ialu_map.vh"
module ialu_chk (
    input wire mclk_i,
    input wire resetn_i,
    input wire start_i,
    input wire [4:0] op_i,
    input wire word_i,
    input wire [15:0] a_i,
    input wire [15:0] b_i,
    input wire [15:0] result_o,
    input wire write_o,
    input wire write_hi_o,
    input wire div_err_o,
    input wire done_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    done_pulse_a: assert property (start_i ##1 !start_i |-> done_o ##1 !done_o)
        else $error("done is not a single pulse after start");
    idle_quiet_a: assert property (!start_i |=> !done_o && !write_o && !write_hi_o && !div_err_o)
        else $error("strobe seen without a start");
    flag_only_a: assert property (start_i && (op_i == `IALU_OP_CMP || op_i == `IALU_OP_TEST) |=> done_o && !write_o)
        else $error("compare or test wrote a result");
    div_err_a: assert property (div_err_o |-> done_o && !write_o && !write_hi_o)
        else $error("divide error with a write");
    byte_upper_a: assert property (start_i && !word_i && op_i inside {`IALU_OP_ADD, `IALU_OP_AND, `IALU_OP_SHL}
        |=> result_o[15:8] == 8'h00)
        else $error("byte result upper byte not clear");
    add_sum_a: assert property (start_i && word_i && op_i == `IALU_OP_ADD |=> result_o == $past(a_i) + $past(b_i))
        else $error("word sum wrong");
    result_hold_a: assert property (!start_i |=> $stable(result_o))
        else $error("result moved without a start");
    xor_self_a: assert property (start_i && op_i == `IALU_OP_XOR && a_i == b_i |=> write_o && result_o == 16'h0000)
        else $error("exclusive or of equal operands not zero");
    not_low_a: assert property (start_i && op_i == `IALU_OP_NOT |=> write_o && result_o[7:0] == ~$past(a_i[7:0]))
        else $error("complement wrong");
    cover property (start_i && op_i == `IALU_OP_RCL);
    cover property (div_err_o);
    cover property (start_i ##1 start_i);
endmodule
bind ialu_core ialu_chk i_ialu_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i),
    .word_i(word_i), .a_i(a_i), .b_i(b_i), .result_o(result_o), .write_o(write_o), .write_hi_o(write_hi_o),
    .div_err_o(div_err_o), .done_o(done_o));
`default_nettype wire

// >>> testbench/ialu_regfile_model.sv
// register file model that stores the datapath write backs
`timescale 1ns/1ns
`default_nettype none
module ialu_regfile_model (
    input wire logic mclk_i,
    input wire logic write_i,
    input wire logic write_hi_i,
    input wire logic [15:0] result_i,
    input wire logic [15:0] result_hi_i,
    output logic [15:0] acc_o,
    output logic [15:0] hi_o
);
    initial begin
        acc_o = 16'h5a5a;
        hi_o = 16'ha5a5;
    end
    always @(posedge mclk_i) begin
        if (write_i) begin
            acc_o <= result_i;
        end
        if (write_hi_i) begin
            hi_o <= result_hi_i;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/integer_alu_shift_rotate_tb_top.sv
// self-checking bench for the integer datapath
`timescale 1ns/1ns
`default_nettype none
`include "ialu_map.vh"
module integer_alu_shift_rotate_tb_top;
    typedef struct packed {
        logic [4:0] op; logic w; logic [15:0] a; logic [15:0] b; logic [5:0] fin;
        logic wr; logic [15:0] res; logic [5:0] fm; logic [5:0] ef;
    } ialu_row_t;
    logic mclk_i, resetn_i, start_i, word_i, count_sel_i, write_o, write_hi_o, div_err_o, done_o;
    logic [4:0] op_i;
    logic [15:0] a_i, b_i, ah_i, result_o, result_hi_o, acc, hi;
    logic [7:0] imm_count_i, count_low_byte;
    logic [5:0] flags_i, flags_o;
    int err_count, checked, cycles;
    ialu_row_t rows [33] = '{
        '{`IALU_OP_ADD, 1, 16'hffff, 16'h0001, 6'h00, 1, 16'h0000, 6'h09, 6'h09},
        '{`IALU_OP_ADC, 0, 16'h007f, 16'h0000, 6'h01, 1, 16'h0080, 6'h39, 6'h30},
        '{`IALU_OP_INC, 0, 16'h00ff, 16'h0000, 6'h01, 1, 16'h0000, 6'h09, 6'h09},
        '{`IALU_OP_SUB, 1, 16'h0000, 16'h0001, 6'h00, 1, 16'hffff, 6'h19, 6'h11},
        '{`IALU_OP_SBB, 0, 16'h0010, 16'h000f, 6'h01, 1, 16'h0000, 6'h09, 6'h08},
        '{`IALU_OP_DEC, 1, 16'h0001, 16'h0000, 6'h01, 1, 16'h0000, 6'h09, 6'h09},
        '{`IALU_OP_NEG, 0, 16'h0001, 16'h0000, 6'h00, 1, 16'h00ff, 6'h09, 6'h01},
        '{`IALU_OP_CMP, 1, 16'h0005, 16'h0005, 6'h01, 0, 16'h0000, 6'h09, 6'h08},
        '{`IALU_OP_MUL, 0, 16'h0010, 16'h0010, 6'h00, 1, 16'h0100, 6'h01, 6'h01},
        '{`IALU_OP_SMUL, 0, 16'h00ff, 16'h0002, 6'h00, 1, 16'hfffe, 6'h01, 6'h00},
        '{`IALU_OP_DIV, 0, 16'h0007, 16'h0002, 6'h00, 1, 16'h0103, 6'h00, 6'h00},
        '{`IALU_OP_SDIV, 0, 16'hfff9, 16'h0002, 6'h00, 1, 16'hfffd, 6'h00, 6'h00},
        '{`IALU_OP_B2W, 0, 16'h0080, 16'h0000, 6'h00, 1, 16'hff80, 6'h00, 6'h00},
        '{`IALU_OP_PADA, 0, 16'h0041, 16'h0000, 6'h04, 1, 16'h0047, 6'h01, 6'h00},
        '{`IALU_OP_PADS, 0, 16'h001f, 16'h0000, 6'h04, 1, 16'h0019, 6'h01, 6'h00},
        '{`IALU_OP_UADA, 0, 16'h000b, 16'h0000, 6'h00, 1, 16'h0101, 6'h01, 6'h01},
        '{`IALU_OP_UADS, 0, 16'h02ff, 16'h0002, 6'h04, 1, 16'h0109, 6'h01, 6'h01},
        '{`IALU_OP_UADM, 0, 16'h0023, 16'h0000, 6'h00, 1, 16'h0305, 6'h08, 6'h00},
        '{`IALU_OP_UADD, 0, 16'h0305, 16'h0003, 6'h00, 1, 16'h0023, 6'h08, 6'h00},
        '{`IALU_OP_NOT, 1, 16'h00ff, 16'h0000, 6'h00, 1, 16'hff00, 6'h00, 6'h00},
        '{`IALU_OP_AND, 1, 16'hf0f0, 16'h0ff0, 6'h21, 1, 16'h00f0, 6'h29, 6'h00},
        '{`IALU_OP_OR, 0, 16'h000f, 16'h00f0, 6'h00, 1, 16'h00ff, 6'h09, 6'h00},
        '{`IALU_OP_XOR, 1, 16'haaaa, 16'haaaa, 6'h00, 1, 16'h0000, 6'h08, 6'h08},
        '{`IALU_OP_TEST, 1, 16'h0f00, 16'h00f0, 6'h01, 0, 16'h0000, 6'h09, 6'h08},
        '{`IALU_OP_SHL, 0, 16'h0081, 16'h0001, 6'h00, 1, 16'h0002, 6'h21, 6'h21},
        '{`IALU_OP_SHL, 1, 16'hffff, 16'h00ff, 6'h00, 1, 16'h0000, 6'h09, 6'h08},
        '{`IALU_OP_SHR, 1, 16'h8000, 16'h000f, 6'h00, 1, 16'h0001, 6'h01, 6'h00},
        '{`IALU_OP_SHR, 1, 16'h1234, 16'h0000, 6'h01, 1, 16'h1234, 6'h01, 6'h01},
        '{`IALU_OP_SAR, 0, 16'h0080, 16'h0003, 6'h00, 1, 16'h00f0, 6'h01, 6'h00},
        '{`IALU_OP_ROL, 0, 16'h0081, 16'h0001, 6'h00, 1, 16'h0003, 6'h01, 6'h01},
        '{`IALU_OP_ROR, 1, 16'h0001, 16'h0001, 6'h00, 1, 16'h8000, 6'h01, 6'h01},
        '{`IALU_OP_RCL, 0, 16'h0080, 16'h0001, 6'h00, 1, 16'h0000, 6'h01, 6'h01},
        '{`IALU_OP_RCR, 1, 16'h0000, 16'h0001, 6'h01, 1, 16'h8000, 6'h01, 6'h00}};
    ialu_core i_ialu_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .start_i(start_i), .op_i(op_i), .word_i(word_i),
        .a_i(a_i), .b_i(b_i), .ah_i(ah_i), .imm_count_i(imm_count_i), .count_register_low_byte_i(count_low_byte),
        .count_sel_i(count_sel_i), .flags_i(flags_i), .result_o(result_o), .result_hi_o(result_hi_o),
        .flags_o(flags_o), .write_o(write_o), .write_hi_o(write_hi_o), .div_err_o(div_err_o), .done_o(done_o));
    ialu_regfile_model i_ialu_regfile_model (.mclk_i(mclk_i), .write_i(write_o), .write_hi_i(write_hi_o),
        .result_i(result_o), .result_hi_i(result_hi_o), .acc_o(acc), .hi_o(hi));
    initial begin
        mclk_i = 0;
        forever #25 mclk_i = ~mclk_i;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            results();
        end
    end
    task automatic chk_val(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_flg(input logic [5:0] m, input logic [5:0] e, input logic [5:0] g);
        checked++;
        if ((g & m) !== (e & m)) begin
            err_count++;
            $display("unexpected flags at %0t: expected %h got %h", $time, e & m, g & m);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected strobe at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    // count travels in both count sources; the unselected one carries the inverse
    task automatic drive(input logic [4:0] op, input logic w, input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] ah, input logic [5:0] fin, input logic sel);
        op_i <= op;
        word_i <= w;
        a_i <= a;
        b_i <= b;
        ah_i <= ah;
        flags_i <= fin;
        count_sel_i <= sel;
        imm_count_i <= sel ? ~b[7:0] : b[7:0];
        count_low_byte <= sel ? b[7:0] : ~b[7:0];
        start_i <= 1'b1;
    endtask
    task automatic issue(input logic [4:0] op, input logic w, input logic [15:0] a, input logic [15:0] b,
        input logic [15:0] ah, input logic [5:0] fin, input logic sel);
        @(posedge mclk_i);
        drive(op, w, a, b, ah, fin, sel);
        @(posedge mclk_i);
        start_i <= 1'b0;
        @(negedge mclk_i);
    endtask
    initial begin
        {start_i, word_i, count_sel_i, op_i, a_i, b_i, ah_i, imm_count_i, count_low_byte, flags_i} = '0;
        resetn_i = 0;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1;
        @(negedge mclk_i);
        chk_val(16'h0000, result_o);
        chk_flg(6'h3f, 6'h00, flags_o);
        chk_bit(1'b0, done_o);
        $display("test reset done");
        for (int i = 0; i < 33; i++) begin
            issue(rows[i].op, rows[i].w, rows[i].a, rows[i].b, rows[i].b, rows[i].fin, i[0]);
            chk_bit(1'b1, done_o);
            chk_bit(rows[i].wr, write_o);
            if (rows[i].wr) begin
                chk_val(rows[i].res, result_o);
            end
            chk_flg(rows[i].fm, rows[i].ef, flags_o);
            $display("test row %0d done", i);
        end
        @(posedge mclk_i);
        drive(`IALU_OP_ADD, 1'b1, 16'h0001, 16'h0002, 16'h0000, 6'h00, 1'b0);
        @(posedge mclk_i);
        drive(`IALU_OP_SUB, 1'b1, 16'h0005, 16'h0003, 16'h0000, 6'h00, 1'b1);
        @(negedge mclk_i);
        chk_val(16'h0003, result_o);
        @(posedge mclk_i);
        start_i <= 1'b0;
        @(negedge mclk_i);
        chk_val(16'h0002, result_o);
        chk_bit(1'b1, done_o);
        $display("test back to back done");
        issue(`IALU_OP_MUL, 1'b1, 16'h1234, 16'h0100, 16'h0000, 6'h00, 1'b0);
        chk_val(16'h3400, result_o);
        chk_val(16'h0012, result_hi_o);
        chk_bit(1'b1, write_hi_o);
        issue(`IALU_OP_DIV, 1'b1, 16'h0005, 16'h0100, 16'h0001, 6'h00, 1'b0);
        chk_val(16'h0100, result_o);
        chk_val(16'h0005, result_hi_o);
        issue(`IALU_OP_TEST, 1'b1, 16'hffff, 16'hffff, 16'h0000, 6'h00, 1'b0);
        chk_val(16'h0100, acc);
        issue(`IALU_OP_DIV, 1'b0, 16'h0010, 16'h0000, 16'h0000, 6'h00, 1'b0);
        chk_bit(1'b1, div_err_o);
        chk_bit(1'b0, write_o);
        issue(`IALU_OP_DIV, 1'b0, 16'h1000, 16'h0002, 16'h0002, 6'h00, 1'b0);
        chk_bit(1'b1, div_err_o);
        issue(`IALU_OP_W2D, 1'b1, 16'h8000, 16'h0000, 16'h0000, 6'h00, 1'b0);
        chk_val(16'hffff, result_hi_o);
        @(negedge mclk_i);
        chk_val(16'hffff, hi);
        $display("test wide results done");
        @(posedge mclk_i);
        resetn_i <= 0;
        @(posedge mclk_i);
        resetn_i <= 1;
        @(negedge mclk_i);
        chk_val(16'h0000, result_o);
        chk_val(16'h0000, result_hi_o);
        $display("test second reset done");
        results();
    end
endmodule
`default_nettype wire
